//--- common/array_timer_params.svh
/*
   Offsets, field positions, reset values and prescale counts of the
   counter array time base. Assumes an 8-bit special function register
   bus with byte addresses.
*/
`ifndef ARRAY_TIMER_PARAMS_SVH
`define ARRAY_TIMER_PARAMS_SVH

// Register byte addresses
`define CTRL_ADDR 8'hD8
`define MODE_ADDR 8'hD9
`define MMODE0_ADDR 8'hDA
`define AUX0_ADDR 8'hF2
`define CNT_HI_ADDR 8'hF9
`define CNT_LO_ADDR 8'hE9
`define RLD_HI_ADDR 8'hCF
`define RLD_LO_ADDR 8'hCE
`define CMPH0_ADDR 8'hFA
`define CMPL0_ADDR 8'hEA

// Reset values and masks of writable and readable bits
`define REG_RESET 8'h00
`define CTRL_WMASK 8'hC3
`define MODE_WMASK 8'h9F
`define AUX_WMASK 8'hC7
`define COUNT_TOP 16'hFFFF

// Field positions
`define CTRL_OVF_BIT 7
`define CTRL_RUN_BIT 6
`define MODE_IDLE_BIT 7
`define MODE_BME_BIT 4
`define MODE_SRC_LSB 1
`define MODE_ECF_BIT 0
`define AUX_RES_LSB 6
`define AUX_INV_BIT 2
`define AUX_HI9_BIT 1
`define AUX_LO9_BIT 0
`define MM_CAPP_BIT 5
`define MM_CAPN_BIT 4
`define MM_TOG_BIT 2
`define MM_PWM_BIT 1
`define MM_ECF_BIT 0

// System clock prescale counts
`define DIV_SLOW 4'd12
`define DIV_FAST 4'd2

`endif

//--- common/array_timer_pkg.sv
/*
   Types shared by the counter array time base modules.
   Assumes nothing of its surroundings.
*/
package array_timer_pkg;
   // Count source encodings, in field order 000..111
   typedef enum logic [2:0] {
      SRC_DIV12, SRC_DIV2, SRC_TIMER0, SRC_EXT,
      SRC_MIXED, SRC_SYS, SRC_BAUD, SRC_MDIV
   } source_sel_type;
   // Per-module resolution field
   typedef logic [1:0] resolution_type;
endpackage

//--- common/count_tick_if.sv
/*
   Carrier between the time base and its count source selector.
   Assumes both ends share one system clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface count_tick_if;
   import array_timer_pkg::*;
   source_sel_type sel;
   logic tick;
   modport ctrl (output sel, input tick);
   modport gen (input sel, output tick);
endinterface
`default_nettype wire

//--- logic/count_source_sel.sv
/*
   Count source selector: prescaler, pin synchronisers and edge detect,
   one-cycle tick on the selected source.
   Assumes pulse inputs are on the system clock; pins are asynchronous.
*/
`timescale 1ns/1ps
`default_nettype none
`include "array_timer_params.svh"
module count_source_sel import array_timer_pkg::*; (
   input wire logic clk,
   input wire logic resetn,
   input wire logic timer0_ovf,
   input wire logic baud_ovf,
   input wire logic [2:0] pins_raw,
   count_tick_if.gen tif
);
   logic [2:0] sync1_r, sync2_r, prev_r;
   logic [3:0] pre_r, pre_nxt;
   logic half_r, half_nxt, tick_r, tick_nxt;
   logic ext_fall, mix_rise, mdiv_rise;

   // Two-stage synchronisers, one per pin source
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_sync
         always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
               sync1_r[g] <= 1'b0;
               sync2_r[g] <= 1'b0;
               prev_r[g] <= 1'b0;
            end else begin
               sync1_r[g] <= pins_raw[g];
               sync2_r[g] <= sync1_r[g];
               prev_r[g] <= sync2_r[g];
            end
         end
      end
   endgenerate

   // Edges seen only after the second stage
   assign ext_fall = prev_r[0] & ~sync2_r[0];
   // Fast sources are sampled, so their edges must stay resolvable
   assign mix_rise = ~prev_r[1] & sync2_r[1];
   assign mdiv_rise = ~prev_r[2] & sync2_r[2];

   // Prescaler and tick selection
   always_comb begin
      pre_nxt = (pre_r == `DIV_SLOW - 4'd1) ? 4'd0 : pre_r + 4'd1;
      half_nxt = ~half_r;
      case (tif.sel)
         SRC_DIV12: tick_nxt = (pre_r == `DIV_SLOW - 4'd1);
         SRC_DIV2: tick_nxt = half_r;
         SRC_TIMER0: tick_nxt = timer0_ovf;
         SRC_EXT: tick_nxt = ext_fall;
         SRC_MIXED: tick_nxt = mix_rise;
         SRC_SYS: tick_nxt = 1'b1;
         SRC_BAUD: tick_nxt = baud_ovf;
         SRC_MDIV: tick_nxt = mdiv_rise;
         default: tick_nxt = 1'b0;
      endcase
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pre_r <= 4'd0;
         half_r <= 1'b0;
         tick_r <= 1'b0;
      end else begin
         pre_r <= pre_nxt;
         half_r <= half_nxt;
         tick_r <= tick_nxt;
      end
   end

   assign tif.tick = tick_r;
endmodule
`default_nettype wire

//--- logic/module_pin_stage.sv
/*
   Output stage of one compare/PWM module: optional inversion and
   pin enable. Assumes port logic falls back to GPIO while oe is low.
*/
`timescale 1ns/1ps
`default_nettype none
module module_pin_stage (
   input wire logic clk,
   input wire logic resetn,
   input wire logic cmp_out,
   input wire logic invert,
   input wire logic uses_pin,
   output logic pin_o,
   output logic pin_oe
);
   logic pin_nxt, oe_nxt;

   // Invert before the pin; release the pin when unused
   always_comb begin
      pin_nxt = cmp_out ^ invert;
      oe_nxt = uses_pin;
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pin_o <= 1'b0;
         pin_oe <= 1'b0;
      end else begin
         pin_o <= pin_nxt;
         pin_oe <= oe_nxt;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   invert_path_a: assert property (##1 pin_o == ($past(cmp_out) ^ $past(invert)))
      else $error("Module pin does not follow inverted compare output");
   pin_release_a: assert property (!uses_pin |=> !pin_oe)
      else $error("Module pin driven while unused");
endmodule
`default_nettype wire

//--- logic/array_time_base.sv
/*
   Counter array time base: 16-bit auto-reload counter, source select,
   idle gating, flags, interrupt request, per-module auxiliary control.
   Assumes a one-cycle SFR write strobe and read strobe on the system
   clock; module match/capture logic lives outside.
*/
// Operation
// - 16-bit counter reloads from reload pair
// - Three-bit field selects eight count sources
// - External source counts pin falling edges
// - Overflow enable gates overflow flag interrupt
// - Overflow toggles clock out, enabled onto pin
// - Idle gate stops counting during CPU idle
// - Buffer pairing needs both modules qualifying
// - Counter runs only while run bit set
// - Overflow flag sticky, cleared only by software
// - Module events set sticky module flags
// - Resolution field picks per-module overflow point
// - Invert bit inverts module output to pin
// - Auxiliary bits extend compares to nine bits in PWM mode
// - One time base serves two modules
// - Unused module pin stays general purpose
// - Module flag enable gates module interrupt
`timescale 1ns/1ps
`default_nettype none
`include "array_timer_params.svh"
module array_time_base import array_timer_pkg::*; #(
   parameter int NUM_MODULES = 2
) (
   input wire logic CLK,
   input wire logic RESETN,
   input wire logic [7:0] SFR_ADDR,
   input wire logic SFR_WR,
   input wire logic SFR_RD,
   input wire logic [7:0] SFR_WDATA,
   output logic [7:0] SFR_RDATA,
   input wire logic CPU_IDLE,
   input wire logic TIMER0_OVF,
   input wire logic BAUD_OVF,
   input wire logic EXTERNAL_COUNT_PIN,
   input wire logic MIXED_CLOCK_SOURCE,
   input wire logic MASTER_DIVIDER_OUTPUT,
   input wire logic CLOCK_OUT_ENABLE,
   input wire logic [NUM_MODULES-1:0] MODULE_EVENT,
   input wire logic [NUM_MODULES-1:0] MODULE_COMPARE_OUTPUT,
   output logic [15:0] COUNT_VALUE,
   output logic [NUM_MODULES-1:0] RES_OVERFLOW,
   output logic [NUM_MODULES*9-1:0] COMPARE_HIGH9,
   output logic [NUM_MODULES*9-1:0] COMPARE_LOW9,
   output logic BUFFER_PAIR_ACTIVE,
   output logic CLOCK_OUT_O,
   output logic CLOCK_OUT_OE,
   output logic [NUM_MODULES-1:0] MODULE_PIN_O,
   output logic [NUM_MODULES-1:0] MODULE_PIN_OE,
   output logic IRQ
);
   logic [7:0] ctrl_r, ctrl_nxt, mode_r, mode_nxt;
   logic [15:0] cnt_r, cnt_nxt, rld_r, rld_nxt;
   logic [NUM_MODULES-1:0][7:0] aux_r, aux_nxt, mm_r, mm_nxt;
   logic [NUM_MODULES-1:0][7:0] cmph_r, cmph_nxt, cmpl_r, cmpl_nxt;
   logic tog_r, tog_nxt, oe_r, oe_nxt, irq_r, irq_nxt;
   logic bpa_r, bpa_nxt, ovf_evt, cnt_en;
   logic [7:0] rd_r, rd_nxt;
   logic [NUM_MODULES-1:0] resovf_r, resovf_nxt, mod_irq, qual;
   logic [NUM_MODULES*9-1:0] hi9_r, hi9_nxt, lo9_r, lo9_nxt;

   count_tick_if tif ();

   // Source selection and tick generation
   count_source_sel u_src (
      .clk(CLK),
      .resetn(RESETN),
      .timer0_ovf(TIMER0_OVF),
      .baud_ovf(BAUD_OVF),
      .pins_raw({MASTER_DIVIDER_OUTPUT, MIXED_CLOCK_SOURCE, EXTERNAL_COUNT_PIN}),
      .tif(tif.gen)
   );
   assign tif.sel = source_sel_type'(mode_r[`MODE_SRC_LSB +: 3]);

   // Count qualification: tick, run bit and idle gate together
   assign cnt_en = tif.tick & ctrl_r[`CTRL_RUN_BIT]
      & ~(mode_r[`MODE_IDLE_BIT] & CPU_IDLE);

   // True when the low bits chosen by the resolution field are all ones
   function automatic logic res_top(input logic [15:0] c, input resolution_type res);
      case (res)
         2'b00: res_top = &c[7:0];
         2'b01: res_top = &c[9:0];
         2'b10: res_top = &c[11:0];
         default: res_top = &c;
      endcase
   endfunction

   // Counter, register writes and sticky flags
   always_comb begin
      ctrl_nxt = ctrl_r;
      mode_nxt = mode_r;
      cnt_nxt = cnt_r;
      rld_nxt = rld_r;
      aux_nxt = aux_r;
      mm_nxt = mm_r;
      cmph_nxt = cmph_r;
      cmpl_nxt = cmpl_r;
      tog_nxt = tog_r;
      ovf_evt = 1'b0;
      // Rollover from all ones reloads, else step by one
      if (cnt_en) begin
         if (cnt_r == `COUNT_TOP) begin
            cnt_nxt = rld_r;
            ovf_evt = 1'b1;
            tog_nxt = ~tog_r;
         end else begin
            cnt_nxt = cnt_r + 16'h0001;
         end
      end
      // A software write to a count byte wins over a tick for that byte only in that cycle
      if (SFR_WR) begin
         case (SFR_ADDR)
            `CTRL_ADDR: ctrl_nxt = SFR_WDATA & `CTRL_WMASK;
            `MODE_ADDR: mode_nxt = SFR_WDATA & `MODE_WMASK;
            `CNT_HI_ADDR: cnt_nxt[15:8] = SFR_WDATA;
            `CNT_LO_ADDR: cnt_nxt[7:0] = SFR_WDATA;
            `RLD_HI_ADDR: rld_nxt[15:8] = SFR_WDATA;
            `RLD_LO_ADDR: rld_nxt[7:0] = SFR_WDATA;
            default: ;
         endcase
         for (int i = 0; i < NUM_MODULES; i++) begin
            // Reserved auxiliary bits are dropped, they read zero
            if (SFR_ADDR == `AUX0_ADDR + 8'(i))
               aux_nxt[i] = SFR_WDATA & `AUX_WMASK;
            if (SFR_ADDR == `MMODE0_ADDR + 8'(i))
               mm_nxt[i] = SFR_WDATA;
            if (SFR_ADDR == `CMPH0_ADDR + 8'(i))
               cmph_nxt[i] = SFR_WDATA;
            if (SFR_ADDR == `CMPL0_ADDR + 8'(i))
               cmpl_nxt[i] = SFR_WDATA;
         end
      end
      // Hardware sets after the write, so a set beats a clear
      ctrl_nxt[`CTRL_OVF_BIT] = ctrl_nxt[`CTRL_OVF_BIT] | ovf_evt;
      ctrl_nxt[NUM_MODULES-1:0] = ctrl_nxt[NUM_MODULES-1:0] | MODULE_EVENT;
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         ctrl_r <= `REG_RESET;
         mode_r <= `REG_RESET;
         cnt_r <= 16'h0000;
         rld_r <= 16'h0000;
         aux_r <= '0;
         mm_r <= '0;
         cmph_r <= '0;
         cmpl_r <= '0;
         tog_r <= 1'b0;
      end else begin
         ctrl_r <= ctrl_nxt;
         mode_r <= mode_nxt;
         cnt_r <= cnt_nxt;
         rld_r <= rld_nxt;
         aux_r <= aux_nxt;
         mm_r <= mm_nxt;
         cmph_r <= cmph_nxt;
         cmpl_r <= cmpl_nxt;
         tog_r <= tog_nxt;
      end
   end

   // Per-module derived outputs: resolution overflow, nine-bit compares
   genvar m;
   generate
      for (m = 0; m < NUM_MODULES; m++) begin : g_mod
         assign resovf_nxt[m] = cnt_en & res_top(cnt_r,
            resolution_type'(aux_r[m][`AUX_RES_LSB +: 2]));
         // Ninth bit only counts in PWM mode
         assign hi9_nxt[m*9 +: 9] = {aux_r[m][`AUX_HI9_BIT] & mm_r[m][`MM_PWM_BIT],
            cmph_r[m]};
         assign lo9_nxt[m*9 +: 9] = {aux_r[m][`AUX_LO9_BIT] & mm_r[m][`MM_PWM_BIT],
            cmpl_r[m]};
         assign mod_irq[m] = ctrl_r[m] & mm_r[m][`MM_ECF_BIT];
         // Capture on either edge or PWM qualify for pairing
         assign qual[m] = mm_r[m][`MM_PWM_BIT] | mm_r[m][`MM_CAPP_BIT]
            | mm_r[m][`MM_CAPN_BIT];
         module_pin_stage u_pin (
            .clk(CLK),
            .resetn(RESETN),
            .cmp_out(MODULE_COMPARE_OUTPUT[m]),
            .invert(aux_r[m][`AUX_INV_BIT]),
            .uses_pin(mm_r[m][`MM_PWM_BIT] | mm_r[m][`MM_TOG_BIT]),
            .pin_o(MODULE_PIN_O[m]),
            .pin_oe(MODULE_PIN_OE[m])
         );
      end
   endgenerate

   // Interrupt, pairing, clock out and read data
   always_comb begin
      irq_nxt = (ctrl_r[`CTRL_OVF_BIT] & mode_r[`MODE_ECF_BIT]) | (|mod_irq);
      bpa_nxt = mode_r[`MODE_BME_BIT] & (&qual);
      oe_nxt = CLOCK_OUT_ENABLE;
      rd_nxt = rd_r;
      if (SFR_RD) begin
         rd_nxt = 8'h00; // Unmapped addresses read zero
         case (SFR_ADDR)
            `CTRL_ADDR: rd_nxt = ctrl_r;
            `MODE_ADDR: rd_nxt = mode_r;
            `CNT_HI_ADDR: rd_nxt = cnt_r[15:8];
            `CNT_LO_ADDR: rd_nxt = cnt_r[7:0];
            `RLD_HI_ADDR: rd_nxt = rld_r[15:8];
            `RLD_LO_ADDR: rd_nxt = rld_r[7:0];
            default: ;
         endcase
         for (int i = 0; i < NUM_MODULES; i++) begin
            if (SFR_ADDR == `AUX0_ADDR + 8'(i))
               rd_nxt = aux_r[i];
            if (SFR_ADDR == `MMODE0_ADDR + 8'(i))
               rd_nxt = mm_r[i];
            if (SFR_ADDR == `CMPH0_ADDR + 8'(i))
               rd_nxt = cmph_r[i];
            if (SFR_ADDR == `CMPL0_ADDR + 8'(i))
               rd_nxt = cmpl_r[i];
         end
      end
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         irq_r <= 1'b0;
         bpa_r <= 1'b0;
         oe_r <= 1'b0;
         rd_r <= 8'h00;
         resovf_r <= '0;
         hi9_r <= '0;
         lo9_r <= '0;
      end else begin
         irq_r <= irq_nxt;
         bpa_r <= bpa_nxt;
         oe_r <= oe_nxt;
         rd_r <= rd_nxt;
         resovf_r <= resovf_nxt;
         hi9_r <= hi9_nxt;
         lo9_r <= lo9_nxt;
      end
   end

   // Every output comes straight from a flip-flop; count is shared by all modules
   assign COUNT_VALUE = cnt_r;
   assign RES_OVERFLOW = resovf_r;
   assign COMPARE_HIGH9 = hi9_r;
   assign COMPARE_LOW9 = lo9_r;
   assign BUFFER_PAIR_ACTIVE = bpa_r;
   assign CLOCK_OUT_O = tog_r;
   assign CLOCK_OUT_OE = oe_r;
   assign IRQ = irq_r;
   assign SFR_RDATA = rd_r;

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESETN);

   ovf_reload_a: assert property (cnt_en && cnt_r == 16'hFFFF && !SFR_WR |=> cnt_r == $past(rld_r))
      else $error("Counter did not reload on overflow");
   count_step_a: assert property (cnt_en && cnt_r != 16'hFFFF && !SFR_WR |=> cnt_r == $past(cnt_r) + 16'h0001)
      else $error("Counter did not step by one");
   run_stop_a: assert property (!ctrl_r[6] && !SFR_WR |=> $stable(cnt_r))
      else $error("Counter moved while stopped");
   idle_hold_a: assert property (mode_r[7] && CPU_IDLE && !SFR_WR |=> $stable(cnt_r))
      else $error("Counter moved during gated idle");
   ovf_flag_a: assert property (ovf_evt |=> ctrl_r[7])
      else $error("Overflow flag not set on rollover");
   flag_sticky_a: assert property (ctrl_r[7] && !(SFR_WR && SFR_ADDR == `CTRL_ADDR) |=> ctrl_r[7])
      else $error("Overflow flag cleared without software");
   event_flag_a: assert property (MODULE_EVENT[0] |=> ctrl_r[0])
      else $error("Module event flag not set");
   irq_gate_a: assert property (ctrl_r[7] && mode_r[0] |=> IRQ)
      else $error("Overflow interrupt not raised");
   irq_quiet_a: assert property (!ctrl_r[7] && !(|mod_irq) |=> !IRQ)
      else $error("Interrupt raised with no enabled flag");
   clock_toggle_a: assert property (ovf_evt |=> CLOCK_OUT_O != $past(CLOCK_OUT_O))
      else $error("Clock out did not toggle on overflow");
   res8_ovf_a: assert property (cnt_en && aux_r[0][7:6] == 2'b00 && cnt_r[7:0] == 8'hFF |=> RES_OVERFLOW[0])
      else $error("Eight-bit resolution overflow missed");
   res16_quiet_a: assert property (cnt_en && aux_r[1][7:6] == 2'b11 && cnt_r != `COUNT_TOP |=> !RES_OVERFLOW[1])
      else $error("Sixteen-bit resolution overflow too early");
   event_flag1_a: assert property (MODULE_EVENT[1] |=> ctrl_r[1])
      else $error("Module one event flag not set");

   // Interrupt and clock-out gating; enables are levels, so both ways are checked
   ovf_irq_off_a: assert property (!mode_r[`MODE_ECF_BIT] && !(|mod_irq) |=> !IRQ)
      else $error("Overflow interrupt raised while disabled");
   clock_oe_on_a: assert property (CLOCK_OUT_ENABLE |=> CLOCK_OUT_OE)
      else $error("Clock out not enabled onto pin");
   clock_oe_off_a: assert property (!CLOCK_OUT_ENABLE |=> !CLOCK_OUT_OE)
      else $error("Clock out driven while disabled");

   // Pairing needs both modules qualifying, not the enable bit alone
   pair_gate_a: assert property (!(&qual) |=> !BUFFER_PAIR_ACTIVE)
      else $error("Buffer pairing active without both modules");
   pair_set_a: assert property (mode_r[`MODE_BME_BIT] && (&qual) |=> BUFFER_PAIR_ACTIVE)
      else $error("Buffer pairing not active");

   // Ninth compare bits appear only in PWM mode
   ninth_clear_a: assert property (!mm_r[0][`MM_PWM_BIT] |=> !COMPARE_HIGH9[8] && !COMPARE_LOW9[8])
      else $error("Ninth compare bit set outside PWM mode");
   ninth_pwm_a: assert property (mm_r[0][`MM_PWM_BIT] |=> COMPARE_HIGH9[8] == $past(aux_r[0][`AUX_HI9_BIT]))
      else $error("Ninth high compare bit lost in PWM mode");
   read_data_a: assert property (SFR_RD && SFR_ADDR == `CNT_LO_ADDR |=> SFR_RDATA == $past(cnt_r[7:0]))
      else $error("Count low byte read back wrong");

   reload_seen_c: cover property (ovf_evt && rld_r != 16'h0000);
   ext_source_c: cover property (cnt_en && mode_r[3:1] == 3'b011);
   irq_seen_c: cover property (IRQ && ctrl_r[0]);
   idle_gate_c: cover property (mode_r[7] && CPU_IDLE && tif.tick && ctrl_r[6]);
   pair_active_c: cover property (BUFFER_PAIR_ACTIVE);
endmodule
`default_nettype wire

//--- test/tb_top.sv
/*
   Self-checking bench for the counter array time base top module.
   Assumes the top module's register map and latencies from its notes.
*/
`timescale 1ns/1ps
`default_nettype none
`include "array_timer_params.svh"
module tb_top;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr_s = 1'b0;
   logic rd_s = 1'b0;
   logic idle = 1'b0;
   logic t0 = 1'b0;
   logic bd = 1'b0;
   logic ext = 1'b1;
   logic mix = 1'b0;
   logic mdo = 1'b0;
   logic coe = 1'b0;
   logic [1:0] ev = 2'b00;
   logic [1:0] cmp = 2'b00;
   logic [7:0] rdata, v;
   logic [15:0] count_value, cv;
   logic [1:0] res_ovf, pin_o, pin_oe;
   logic [17:0] high9, low9;
   logic pair, ck_o, ck_oe, irq, seen0, seen1, co;
   int failures = 0;
   int n_compared = 0;
   int cycles = 0;
   int i;
   logic [7:0] lo_t [8] = '{8'd1, 8'd11, 8'd5, 8'd5, 8'd5, 8'd23, 8'd5, 8'd5};
   logic [7:0] hi_t [8] = '{8'd3, 8'd14, 8'd5, 8'd5, 8'd5, 8'd27, 8'd5, 8'd5};

   array_time_base DUT (.CLK(clk), .RESETN(resetn), .SFR_ADDR(addr), .SFR_WR(wr_s),
      .SFR_RD(rd_s), .SFR_WDATA(wdata), .SFR_RDATA(rdata), .CPU_IDLE(idle),
      .TIMER0_OVF(t0), .BAUD_OVF(bd), .EXTERNAL_COUNT_PIN(ext),
      .MIXED_CLOCK_SOURCE(mix), .MASTER_DIVIDER_OUTPUT(mdo), .CLOCK_OUT_ENABLE(coe),
      .MODULE_EVENT(ev), .MODULE_COMPARE_OUTPUT(cmp), .COUNT_VALUE(count_value),
      .RES_OVERFLOW(res_ovf), .COMPARE_HIGH9(high9), .COMPARE_LOW9(low9),
      .BUFFER_PAIR_ACTIVE(pair), .CLOCK_OUT_O(ck_o), .CLOCK_OUT_OE(ck_oe),
      .MODULE_PIN_O(pin_o), .MODULE_PIN_OE(pin_oe), .IRQ(irq));

   // Free-running 25 MHz clock
   initial begin
      forever #20 clk = ~clk;
   end

   // Hang guard; the whole run needs under a thousand cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles > 20000) begin
         failures++;
         end_sim();
      end
   end

   task automatic end_sim();
      $display("compared %0d, mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask

   // Strobe high for one edge, then an idle edge so strobes never merge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      addr = a;
      wdata = d;
      wr_s = 1'b1;
      @(negedge clk);
      wr_s = 1'b0;
      @(negedge clk);
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      addr = a;
      rd_s = 1'b1;
      @(negedge clk);
      rd_s = 1'b0;
      d = rdata;
      @(negedge clk);
   endtask

   task automatic done(input string s);
      $display("test %s finished", s);
   endtask

   // Clear count, run with mode m, feed n source events, idle cyc, stop, read low byte
   task automatic run_src(input logic [7:0] m, input int n, input int cyc,
         output logic [7:0] d);
      wr(`MODE_ADDR, m);
      wr(`CNT_HI_ADDR, 8'h00);
      wr(`CNT_LO_ADDR, 8'h00);
      wr(`CTRL_ADDR, 8'h40);
      for (int k = 0; k < n; k++) begin
         case (m[3:1])
            3'd2: t0 = 1'b1;
            3'd6: bd = 1'b1;
            3'd3: ext = 1'b0;
            3'd4: mix = 1'b1;
            default: mdo = 1'b1;
         endcase
         @(negedge clk);
         t0 = 1'b0;
         bd = 1'b0;
         ext = 1'b1;
         mix = 1'b0;
         mdo = 1'b0;
         repeat (6) @(negedge clk);
      end
      repeat (cyc) @(negedge clk);
      wr(`CTRL_ADDR, 8'h00);
      rd(`CNT_LO_ADDR, d);
   endtask

   initial begin
      repeat (3) @(negedge clk);
      resetn = 1'b1;
      @(negedge clk);
      // Reset values, unmapped and reserved bits
      foreach (lo_t[j]) begin
      end
      rd(`CTRL_ADDR, v); check(v, 8'h00);
      rd(`MODE_ADDR, v); check(v, 8'h00);
      rd(`AUX0_ADDR, v); check(v, 8'h00);
      wr(8'h10, 8'hFF);
      rd(8'h10, v); check(v, 8'h00);
      wr(`CTRL_ADDR, 8'h80);
      rd(`CTRL_ADDR, v); check(v, 8'h80);
      wr(`MODE_ADDR, 8'hFF);
      rd(`MODE_ADDR, v); check(v, 8'h9F);
      wr(`AUX0_ADDR, 8'hC7);
      rd(`AUX0_ADDR, v); check(v, 8'hC7);
      done("registers");
      // Every count source; pulsed sources must give exactly five
      for (i = 0; i < 8; i++) begin
         run_src({4'h0, i[2:0], 1'b0}, (i == 0 || i == 1 || i == 5) ? 0 : 5, 24, v);
         check(v >= lo_t[i] && v <= hi_t[i], 1'b1);
      end
      // Fastest source selected so a stopped counter would show any leak
      wr(`MODE_ADDR, 8'h0A);
      cv = count_value;
      repeat (10) @(negedge clk);
      check(count_value, cv);
      done("sources");
      // Idle gating both ways
      idle = 1'b1;
      run_src(8'h8A, 0, 24, v); check(v, 8'h00);
      run_src(8'h0A, 0, 24, v); check(v >= 8'd23, 1'b1);
      idle = 1'b0;
      done("idle");
      // Overflow reloads, sets flag, toggles clock out, interrupt gated
      wr(`RLD_HI_ADDR, 8'h12);
      wr(`RLD_LO_ADDR, 8'h34);
      wr(`CNT_HI_ADDR, 8'hFF);
      wr(`CNT_LO_ADDR, 8'hF0);
      co = ck_o;
      wr(`CTRL_ADDR, 8'h40);
      for (i = 0; i < 200 && count_value !== 16'h1234; i++) @(negedge clk);
      check(count_value, 16'h1234);
      check(ck_o, !co);
      check(irq, 1'b0);
      rd(`CTRL_ADDR, v); check(v, 8'hC0);
      wr(`MODE_ADDR, 8'h0B);
      @(negedge clk);
      check(irq, 1'b1);
      wr(`CTRL_ADDR, 8'h00);
      rd(`CTRL_ADDR, v); check(v, 8'h00);
      check(irq, 1'b0);
      coe = 1'b1;
      repeat (2) @(negedge clk);
      check(ck_oe, 1'b1);
      wr(`MODE_ADDR, 8'h00);
      done("overflow");
      // Module flags and their interrupt enables
      ev = 2'b01;
      @(negedge clk);
      ev = 2'b00;
      rd(`CTRL_ADDR, v); check(v, 8'h01);
      check(irq, 1'b0);
      wr(`MMODE0_ADDR, 8'h01);
      @(negedge clk);
      check(irq, 1'b1);
      ev = 2'b10;
      @(negedge clk);
      ev = 2'b00;
      wr(`CTRL_ADDR, 8'h02);
      rd(`CTRL_ADDR, v); check(v, 8'h02);
      check(irq, 1'b0);
      wr(`CTRL_ADDR, 8'h00);
      done("flags");
      // Pins, inversion, ninth bits, pairing
      wr(`AUX0_ADDR, 8'h07);
      wr(`MMODE0_ADDR, 8'h02);
      wr(`CMPH0_ADDR, 8'hAB);
      wr(`CMPL0_ADDR, 8'hCD);
      cmp = 2'b01;
      repeat (2) @(negedge clk);
      check(pin_oe, 2'b01);
      check(pin_o, 2'b00);
      check(high9[8:0], 9'h1AB);
      check(low9[8:0], 9'h1CD);
      wr(`MODE_ADDR, 8'h10);
      repeat (2) @(negedge clk);
      check(pair, 1'b0);
      wr(8'hDB, 8'h02);
      wr(`AUX0_ADDR, 8'h03);
      repeat (2) @(negedge clk);
      check(pair, 1'b1);
      check(pin_o, 2'b01);
      done("pins");
      // Resolution overflow: 8-bit point seen, 16-bit not
      wr(8'hF3, 8'hC0);
      wr(`MODE_ADDR, 8'h0A);
      wr(`CNT_HI_ADDR, 8'h00);
      wr(`CNT_LO_ADDR, 8'hF8);
      wr(`CTRL_ADDR, 8'h40);
      seen0 = 1'b0;
      seen1 = 1'b0;
      for (i = 0; i < 30; i++) begin
         seen0 = seen0 | res_ovf[0];
         seen1 = seen1 | res_ovf[1];
         @(negedge clk);
      end
      wr(`CTRL_ADDR, 8'h00);
      check(seen0, 1'b1);
      check(seen1, 1'b0);
      done("resolution");
      end_sim();
   end
endmodule
`default_nettype wire
